/* File: verilog/pmws_pkg.sv */
// Purpose: shared constants for the PCI master write sequencer ends
// Assumes: one 20 MHz clock for both ends
// Notes: status vector bit positions and command codes
`default_nettype none
package pmws_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Status vector bits
  localparam int unsigned TSR_REQ = 0;
  localparam int unsigned TSR_GNT = 1;
  localparam int unsigned TSR_XFER = 2;
  localparam int unsigned TSR_DONE = 7;
  localparam logic [7:0] TSR_RST = 8'h00;
  // Write commands; bit 2 set marks a memory write
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [3:0] CMD_MWI = 4'hF;
  localparam int unsigned CMD_MEM_BIT = 2;
  localparam logic [3:0] BE_BURST = 4'h0;
  // Controller register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_SEED = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  // Control field positions
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_THROTTLE = 1;
  localparam int unsigned CTRL_CMD_LSB = 4;
  localparam int unsigned CTRL_CNT_LSB = 8;
  localparam int unsigned CTRL_BE_LSB = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
endpackage : pmws_pkg
`default_nettype wire

/* File: verilog/pmws_link_if.sv */
// Purpose: local-side link between application and PCI master sequencer
// Assumes: both ends share clk
// Notes: active-low strobes end in _n
`default_nettype none
interface pmws_link_if;
  logic local_master_request_n;
  logic [31:0] local_address_in_bus;
  logic [3:0] local_command_byte_enable_bus;
  logic [31:0] local_write_data;
  logic local_last_transfer_n;
  logic local_side_busy_n;
  logic local_transfer_acknowledge_n;
  logic [7:0] master_transaction_status_vector;
  modport device (
    input local_master_request_n,
    input local_address_in_bus,
    input local_command_byte_enable_bus,
    input local_write_data,
    input local_last_transfer_n,
    input local_side_busy_n,
    output local_transfer_acknowledge_n,
    output master_transaction_status_vector
  );
  modport local_app (
    output local_master_request_n,
    output local_address_in_bus,
    output local_command_byte_enable_bus,
    output local_write_data,
    output local_last_transfer_n,
    output local_side_busy_n,
    input local_transfer_acknowledge_n,
    input master_transaction_status_vector
  );
endinterface : pmws_link_if
`default_nettype wire

/* File: verilog/pmws_local_app.sv */
// Purpose: local-side application issuing write transactions, run over APB
// Assumes: pready always high, zero wait states
// Notes: write data words are seed, seed+1, ...
`default_nettype none
module pmws_local_app (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pmws_link_if.local_app lnk
);
  typedef enum logic [1:0] {
    PMWS_H_IDLE = 2'b00,
    PMWS_H_REQ = 2'b01,
    PMWS_H_SEND = 2'b10,
    PMWS_H_DRAIN = 2'b11
  } pmws_hst_t;

  pmws_hst_t st_r, st_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [31:0] seed_r, seed_nxt;
  logic [7:0] sent_r, sent_nxt;
  logic thr_r, thr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_en;
  logic [7:0] cnt;
  logic last_word;

  assign wr_en = psel & penable & pwrite;
  assign cnt = ctrl_r[pmws_pkg::CTRL_CNT_LSB +: 8];
  assign last_word = (sent_r + 8'h01 >= cnt);
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = rdata_r;

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt = st_r;
    ctrl_nxt = ctrl_r;
    addr_nxt = addr_r;
    seed_nxt = seed_r;
    sent_nxt = sent_r;
    thr_nxt = ctrl_r[pmws_pkg::CTRL_THROTTLE] ? ~thr_r : 1'b0;
    rdata_nxt = rdata_r;
    if (psel & ~penable & ~pwrite)
    begin
      unique case (paddr)
        pmws_pkg::OFS_CTRL: rdata_nxt = ctrl_r;
        pmws_pkg::OFS_ADDR: rdata_nxt = addr_r;
        pmws_pkg::OFS_SEED: rdata_nxt = seed_r;
        pmws_pkg::OFS_STAT: rdata_nxt = {8'h00, sent_r,
          lnk.master_transaction_status_vector, 7'h00, st_r != PMWS_H_IDLE};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    unique case (st_r)
      PMWS_H_IDLE:
        if (ctrl_r[pmws_pkg::CTRL_GO] && cnt != 8'h00)
        begin
          ctrl_nxt[pmws_pkg::CTRL_GO] = 1'b0;
          sent_nxt = 8'h00;
          st_nxt = PMWS_H_REQ;
        end
      PMWS_H_REQ:
        st_nxt = PMWS_H_SEND;
      PMWS_H_SEND:
        if (~lnk.local_transfer_acknowledge_n)
        begin
          sent_nxt = sent_r + 8'h01;
          if (last_word)
            st_nxt = PMWS_H_DRAIN;
        end
      PMWS_H_DRAIN:
        if (lnk.master_transaction_status_vector == pmws_pkg::TSR_RST)
          st_nxt = PMWS_H_IDLE;
    endcase
    // Software write after the hardware clear, so a new GO wins
    if (wr_en)
    begin
      unique case (paddr)
        pmws_pkg::OFS_CTRL: ctrl_nxt = pwdata;
        pmws_pkg::OFS_ADDR: addr_nxt = pwdata;
        pmws_pkg::OFS_SEED: seed_nxt = pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= PMWS_H_IDLE;
      ctrl_r <= pmws_pkg::CTRL_RST;
      addr_r <= 32'h0000_0000;
      seed_r <= 32'h0000_0000;
      sent_r <= 8'h00;
      thr_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      st_r <= st_nxt;
      ctrl_r <= ctrl_nxt;
      addr_r <= addr_nxt;
      seed_r <= seed_nxt;
      sent_r <= sent_nxt;
      thr_r <= thr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Request with address and command in one cycle
  assign lnk.local_master_request_n = (st_r != PMWS_H_REQ);
  assign lnk.local_address_in_bus = addr_r;
  assign lnk.local_command_byte_enable_bus = (st_r == PMWS_H_REQ) ?
    ctrl_r[pmws_pkg::CTRL_CMD_LSB +: 4] : ctrl_r[pmws_pkg::CTRL_BE_LSB +: 4];
  assign lnk.local_write_data = seed_r + {24'h000000, sent_r};
  // Single word: last held from the request on; burst: with final word
  assign lnk.local_last_transfer_n = ~((st_r == PMWS_H_REQ && cnt == 8'h01) ||
    (st_r == PMWS_H_SEND && last_word));
  assign lnk.local_side_busy_n = ~(thr_r & (st_r == PMWS_H_SEND));
endmodule : pmws_local_app
`default_nettype wire

/* File: verilog/pmws_pci_master.sv */
// Purpose: PCI master write sequencer, single-cycle and burst writes
// Assumes: PCI pins on clk; arbiter and targets keep PCI protocol
// Notes: reads and abnormal terminations are not handled
`default_nettype none
module pmws_pci_master (
  input wire logic clk,
  input wire logic rst_b,
  pmws_link_if.device lnk,
  output logic req_n,
  input wire logic gnt_n,
  input wire logic [31:0] ad_i,
  output logic [31:0] ad_o,
  output logic ad_oe,
  input wire logic [3:0] cbe_i,
  output logic [3:0] cbe_o,
  output logic cbe_oe,
  input wire logic frame_i_n,
  output logic frame_o_n,
  output logic frame_oe,
  input wire logic irdy_i_n,
  output logic irdy_o_n,
  output logic irdy_oe,
  input wire logic trdy_n,
  input wire logic devsel_n
);
  typedef enum logic [2:0] {
    PMWS_D_IDLE = 3'b000,
    PMWS_D_REQ = 3'b001,
    PMWS_D_GNT = 3'b010,
    PMWS_D_ADDR = 3'b011,
    PMWS_D_DATA = 3'b100,
    PMWS_D_TURN = 3'b101
  } pmws_dst_t;

  pmws_dst_t st_r, st_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [3:0] cmd_r, cmd_nxt;
  logic [3:0] be_r, be_nxt;
  logic single_r, single_nxt;
  logic early_last_r, early_last_nxt;
  logic [31:0] dreg_r, dreg_nxt;
  logic dval_r, dval_nxt;
  logic dlast_r, dlast_nxt;
  logic [31:0] skid_r, skid_nxt;
  logic sval_r, sval_nxt;
  logic slast_r, slast_nxt;
  logic last_taken_r, last_taken_nxt;
  logic busy_r, busy_nxt;
  logic twait_r, twait_nxt;
  logic [7:0] tsr_r, tsr_nxt;
  logic bus_idle;
  logic irdy_act;
  logic phase_done;
  logic ack;
  logic take_last;
  logic is_mem;

  ////////////////////////////////////////////////////////////////////
  assign bus_idle = frame_i_n & irdy_i_n;
  assign irdy_act = (st_r == PMWS_D_DATA) & dval_r;
  assign phase_done = irdy_act & ~trdy_n;
  // Memory write and invalidate share one path
  assign is_mem = cmd_r[pmws_pkg::CMD_MEM_BIT];
  // Accept only with room, no busy last clock, no target wait last clock
  assign ack = ((st_r == PMWS_D_ADDR) | (st_r == PMWS_D_DATA)) & ~busy_r
    & ~twait_r & ~sval_r & ~last_taken_r;
  assign take_last = single_r | (st_r == PMWS_D_ADDR) | ~lnk.local_last_transfer_n;
  assign lnk.local_transfer_acknowledge_n = ~ack;
  assign lnk.master_transaction_status_vector = tsr_r;

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    cmd_nxt = cmd_r;
    be_nxt = be_r;
    single_nxt = single_r;
    early_last_nxt = early_last_r;
    dreg_nxt = dreg_r;
    dval_nxt = dval_r;
    dlast_nxt = dlast_r;
    skid_nxt = skid_r;
    sval_nxt = sval_r;
    slast_nxt = slast_r;
    last_taken_nxt = last_taken_r;
    busy_nxt = ~lnk.local_side_busy_n & (st_r != PMWS_D_IDLE);
    twait_nxt = irdy_act & trdy_n;
    unique case (st_r)
      PMWS_D_IDLE:
        if (~lnk.local_master_request_n)
        begin
          addr_nxt = lnk.local_address_in_bus;
          cmd_nxt = lnk.local_command_byte_enable_bus;
          early_last_nxt = ~lnk.local_last_transfer_n;
          dval_nxt = 1'b0;
          sval_nxt = 1'b0;
          last_taken_nxt = 1'b0;
          st_nxt = PMWS_D_REQ;
        end
      PMWS_D_REQ:
        if (~gnt_n && bus_idle)
          st_nxt = PMWS_D_GNT;
      PMWS_D_GNT:
        st_nxt = PMWS_D_ADDR;
      PMWS_D_ADDR:
      begin
        be_nxt = lnk.local_command_byte_enable_bus;
        single_nxt = ~is_mem | early_last_r | ~lnk.local_last_transfer_n;
        st_nxt = PMWS_D_DATA;
      end
      PMWS_D_DATA:
        if (phase_done && dlast_r)
          st_nxt = PMWS_D_TURN;
      PMWS_D_TURN:
        st_nxt = PMWS_D_IDLE;
      default:
        st_nxt = PMWS_D_IDLE;
    endcase
    // Early last seen any time before the address phase
    if ((st_r == PMWS_D_REQ || st_r == PMWS_D_GNT) && ~lnk.local_last_transfer_n)
      early_last_nxt = 1'b1;
    // Drain the phase register, refill from skid
    if (phase_done)
    begin
      dval_nxt = sval_r;
      dreg_nxt = skid_r;
      dlast_nxt = slast_r;
      sval_nxt = 1'b0;
    end
    if (ack)
    begin
      // Once last is taken, further last cycles do nothing
      last_taken_nxt = (st_r == PMWS_D_ADDR) ?
        (~is_mem | early_last_r | ~lnk.local_last_transfer_n) : take_last;
      if (!dval_r || phase_done)
      begin
        dreg_nxt = lnk.local_write_data;
        dval_nxt = 1'b1;
        dlast_nxt = (st_r == PMWS_D_ADDR) ? last_taken_nxt : take_last;
      end
      else
      begin
        skid_nxt = lnk.local_write_data;
        sval_nxt = 1'b1;
        slast_nxt = take_last;
      end
    end
  end

  // Status vector follows the coming state
  always_comb
  begin
    tsr_nxt = pmws_pkg::TSR_RST;
    tsr_nxt[pmws_pkg::TSR_REQ] = (st_nxt == PMWS_D_REQ);
    tsr_nxt[pmws_pkg::TSR_GNT] = (st_nxt == PMWS_D_GNT) | (st_nxt == PMWS_D_ADDR);
    tsr_nxt[pmws_pkg::TSR_XFER] = (st_nxt == PMWS_D_DATA);
    tsr_nxt[pmws_pkg::TSR_DONE] = phase_done;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= PMWS_D_IDLE;
      addr_r <= 32'h0000_0000;
      cmd_r <= 4'h0;
      be_r <= 4'h0;
      single_r <= 1'b0;
      early_last_r <= 1'b0;
      dreg_r <= 32'h0000_0000;
      dval_r <= 1'b0;
      dlast_r <= 1'b0;
      skid_r <= 32'h0000_0000;
      sval_r <= 1'b0;
      slast_r <= 1'b0;
      last_taken_r <= 1'b0;
      busy_r <= 1'b0;
      twait_r <= 1'b0;
      tsr_r <= pmws_pkg::TSR_RST;
    end
    else
    begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      cmd_r <= cmd_nxt;
      be_r <= be_nxt;
      single_r <= single_nxt;
      early_last_r <= early_last_nxt;
      dreg_r <= dreg_nxt;
      dval_r <= dval_nxt;
      dlast_r <= dlast_nxt;
      skid_r <= skid_nxt;
      sval_r <= sval_nxt;
      slast_r <= slast_nxt;
      last_taken_r <= last_taken_nxt;
      busy_r <= busy_nxt;
      twait_r <= twait_nxt;
      tsr_r <= tsr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // PCI pins
  assign req_n = ~((st_r == PMWS_D_REQ) | (st_r == PMWS_D_GNT));
  assign ad_oe = (st_r == PMWS_D_GNT) | (st_r == PMWS_D_ADDR) | (st_r == PMWS_D_DATA);
  assign cbe_oe = ad_oe;
  assign frame_oe = ad_oe;
  assign irdy_oe = ad_oe | (st_r == PMWS_D_TURN);
  assign ad_o = (st_r == PMWS_D_DATA) ? dreg_r : addr_r;
  assign cbe_o = (st_r == PMWS_D_DATA) ? (single_r ? be_r : pmws_pkg::BE_BURST) : cmd_r;
  // Burst: frame stays low until the last word sits in the phase register; single: frame high from the data phase on
  assign frame_o_n = ~((st_r == PMWS_D_ADDR) |
    ((st_r == PMWS_D_DATA) & ~(single_r | (dval_r & dlast_r))));
  assign irdy_o_n = ~irdy_act;
endmodule : pmws_pci_master
`default_nettype wire

/* File: testbench/pmws_chk_sva.sv */
// Purpose: link and PCI pin checks for the write sequencer
// Assumes: one clock, rst_b active low
// Notes: instantiated beside the link interface
`default_nettype none
module pmws_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic local_master_request_n,
  input wire logic local_side_busy_n,
  input wire logic local_transfer_acknowledge_n,
  input wire logic [7:0] master_transaction_status_vector,
  input wire logic req_n,
  input wire logic gnt_n,
  input wire logic frame_i_n,
  input wire logic irdy_i_n,
  input wire logic frame_o_n,
  input wire logic frame_oe,
  input wire logic irdy_o_n,
  input wire logic irdy_oe,
  input wire logic ad_oe,
  input wire logic [3:0] cbe_o,
  input wire logic cbe_oe,
  input wire logic trdy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] st;
  assign st = master_transaction_status_vector;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_addr;
    frame_oe && !frame_o_n && $past(frame_oe) && $past(frame_o_n);
  endsequence
  sequence s_fin;
    irdy_oe && !irdy_o_n && !trdy_n && frame_o_n;
  endsequence
  property p_req;
    $fell(local_master_request_n) && st == 8'h00 |=> st[0] && !req_n;
  endproperty
  property p_addr;
    s_addr |-> !$past(gnt_n, 2) && $past(frame_i_n, 2) && $past(irdy_i_n, 2);
  endproperty
  property p_gnt;
    st == 8'h02 && frame_o_n |-> frame_oe && ad_oe && !req_n ##1 !frame_o_n && req_n;
  endproperty
  property p_io;
    s_addr ##0 !cbe_o[2] |=> frame_o_n && !irdy_o_n;
  endproperty
  property p_data;
    s_addr ##1 frame_o_n |-> !irdy_o_n && irdy_oe && ad_oe && st[2];
  endproperty
  property p_done;
    st[7] == ($past(irdy_oe) && !$past(irdy_o_n) && !$past(trdy_n));
  endproperty
  property p_turn;
    s_fin |=> irdy_oe && irdy_o_n && !ad_oe && !cbe_oe && !frame_oe ##1 !irdy_oe;
  endproperty
  property p_clear;
    s_fin |-> ##2 st == pmws_pkg::TSR_RST;
  endproperty
  property p_busy;
    !local_side_busy_n |=> local_transfer_acknowledge_n;
  endproperty
  property p_twait;
    st[2] && irdy_oe && !irdy_o_n && trdy_n |=> local_transfer_acknowledge_n;
  endproperty
  property p_ack;
    !local_transfer_acknowledge_n |-> frame_oe && !frame_o_n;
  endproperty
  a_req: assert property (p_req) else $error("request not raised");
  a_addr: assert property (p_addr) else $error("address phase too early");
  a_gnt: assert property (p_gnt) else $error("grant cycle wrong");
  a_io: assert property (p_io) else $error("io write not single");
  a_data: assert property (p_data) else $error("data cycle wrong");
  a_done: assert property (p_done) else $error("done bit wrong");
  a_turn: assert property (p_turn) else $error("turnaround wrong");
  a_clear: assert property (p_clear) else $error("status not clear");
  a_busy: assert property (p_busy) else $error("ack after busy");
  a_twait: assert property (p_twait) else $error("ack after target wait");
  a_ack: assert property (p_ack) else $error("ack outside transfer");
endmodule : pmws_chk
`default_nettype wire

/* File: testbench/pci_master_write_sequencer_bench.sv */
// Purpose: both ends joined, driven over APB, bench acts as arbiter and target
// Assumes: 20 MHz clock, target never aborts
// Notes: target waits every fourth cycle when wt is set
`default_nettype none
module pci_master_write_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, ad_o;
  logic pready, pslverr, req_n, ad_oe, cbe_oe, frame_o_n, frame_oe, irdy_o_n, irdy_oe;
  logic frame_i_n, irdy_i_n;
  logic gnt_n = 1'h1;
  logic trdy_n = 1'h1;
  logic wt = 1'h0;
  logic pf = 1'h1;
  logic [1:0] cyc = 2'h0;
  logic [2:0] gd = 3'h0;
  logic [3:0] cbe_o;
  logic [31:0] dq[$];
  logic [3:0] bq[$];
  logic [35:0] aq[$];
  int err_total = 0;
  int check_count = 0;
  pmws_link_if lnk();
  always #25 clk = ~clk;
  // Pull-ups on released control lines
  assign frame_i_n = frame_oe ? frame_o_n : 1'h1;
  assign irdy_i_n = irdy_oe ? irdy_o_n : 1'h1;
  pmws_local_app i_pmws_local_app (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(lnk));
  pmws_pci_master i_pmws_pci_master (.clk(clk), .rst_b(rst_b), .lnk(lnk), .req_n(req_n),
    .gnt_n(gnt_n), .ad_i(ad_o), .ad_o(ad_o), .ad_oe(ad_oe), .cbe_i(cbe_o), .cbe_o(cbe_o),
    .cbe_oe(cbe_oe), .frame_i_n(frame_i_n), .frame_o_n(frame_o_n), .frame_oe(frame_oe),
    .irdy_i_n(irdy_i_n), .irdy_o_n(irdy_o_n), .irdy_oe(irdy_oe), .trdy_n(trdy_n),
    .devsel_n(1'h0));
  pmws_chk i_pmws_chk (.clk(clk), .rst_b(rst_b),
    .local_master_request_n(lnk.local_master_request_n),
    .local_side_busy_n(lnk.local_side_busy_n),
    .local_transfer_acknowledge_n(lnk.local_transfer_acknowledge_n),
    .master_transaction_status_vector(lnk.master_transaction_status_vector),
    .req_n(req_n), .gnt_n(gnt_n), .frame_i_n(frame_i_n), .irdy_i_n(irdy_i_n),
    .frame_o_n(frame_o_n), .frame_oe(frame_oe), .irdy_o_n(irdy_o_n), .irdy_oe(irdy_oe),
    .ad_oe(ad_oe), .cbe_o(cbe_o), .cbe_oe(cbe_oe), .trdy_n(trdy_n));
  ////////////////////////////////////////////////////////////////////////////////
  // Arbiter grants late, target waits, monitor records phases
  always @(posedge clk)
  begin
    cyc <= cyc + 2'h1;
    trdy_n <= wt && cyc == 2'h0;
    gd <= req_n ? 3'h0 : gd + 3'h1;
    gnt_n <= !(!req_n && gd >= 3'h3);
    pf <= frame_o_n || !frame_oe;
    if (frame_oe && !frame_o_n && pf)
      aq.push_back({cbe_o, ad_o});
    if (irdy_oe && !irdy_o_n && !trdy_n)
    begin
      dq.push_back(ad_o);
      bq.push_back(cbe_o);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic run(input logic [3:0] cmd, input logic [7:0] cnt, input logic [3:0] be,
    input logic thr);
    dq.delete();
    bq.delete();
    aq.delete();
    apb(1'h1, pmws_pkg::OFS_SEED, 32'h0000_A000);
    apb(1'h1, pmws_pkg::OFS_ADDR, {28'h0000_040, cmd});
    apb(1'h1, pmws_pkg::OFS_CTRL, {12'h000, be, cnt, cmd, 2'h0, thr, 1'h1});
    repeat (3) @(posedge clk);
    for (int i = 0; i < 100; i++)
    begin
      apb(1'h0, pmws_pkg::OFS_STAT, 32'h0000_0000);
      if (rd[0] === 1'h0 && rd[15:8] === 8'h00) break;
    end
    chk("drained", {16'h0000, rd[15:8], 7'h00, rd[0]}, 32'h0000_0000);
    chk("address phases", aq.size(), 32'h0000_0001);
    chk("address", aq[0][31:0], {28'h0000_040, cmd});
    chk("command", {28'h0000_000, aq[0][35:32]}, {28'h0000_000, cmd});
    chk("phases", dq.size(), {24'h00_0000, cnt});
    for (int i = 0; i < dq.size(); i++)
      chk("word", dq[i], 32'h0000_A000 + i);
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(1'h0, pmws_pkg::OFS_CTRL, 32'h0000_0000);
    chk("ctrl reset", rd, pmws_pkg::CTRL_RST);
    chk("slave error", {31'h0000_000, pslverr}, 32'h0000_0000);
    apb(1'h1, 8'h10, 32'hFFFF_FFFF);
    apb(1'h0, 8'h10, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    apb(1'h0, pmws_pkg::OFS_STAT, 32'h0000_0000);
    chk("idle status", {24'h00_0000, rd[15:8]}, {24'h00_0000, pmws_pkg::TSR_RST});
  endtask : t_regs
  task automatic t_single;
    logic [3:0] cl[3];
    cl = '{pmws_pkg::CMD_IO_WR, pmws_pkg::CMD_CFG_WR, pmws_pkg::CMD_MEM_WR};
    foreach (cl[k])
    begin
      run(cl[k], 8'h01, 4'hA, 1'h0);
      chk("byte enables", {28'h0000_000, bq[0]}, 32'h0000_000A);
    end
  endtask : t_single
  task automatic t_burst(input logic [3:0] cmd, input logic thr);
    wt <= thr;
    run(cmd, 8'h06, 4'hA, thr);
    chk("words sent", {24'h00_0000, rd[23:16]}, 32'h0000_0006);
    foreach (bq[k])
      chk("burst enables", {28'h0000_000, bq[k]}, {28'h0000_000, pmws_pkg::BE_BURST});
    wt <= 1'h0;
  endtask : t_burst
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    t_regs();
    t_single();
    t_burst(pmws_pkg::CMD_MEM_WR, 1'h1);
    t_burst(pmws_pkg::CMD_MWI, 1'h0);
    t_burst(pmws_pkg::CMD_MWI, 1'h1);
    close_out();
  end
  initial
  begin
    #2000000;
    err_total++;
    close_out();
  end
endmodule : pci_master_write_sequencer_bench
`default_nettype wire
